//--- include/mbpwm_pkg.sv
package mbpwm_pkg;
  localparam int unsigned NUM_MATCH     = 7;
  localparam int unsigned NUM_OUT       = 6;
  localparam int unsigned NUM_CAP       = 2;
  localparam int unsigned NUM_IRQ       = 9;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h00;
  localparam logic [7:0]  OFS_CTRL      = 8'h04;
  localparam logic [7:0]  OFS_COUNT     = 8'h08;
  localparam logic [7:0]  OFS_PRE_MAX   = 8'h0c;
  localparam logic [7:0]  OFS_PRE_CNT   = 8'h10;
  localparam logic [7:0]  OFS_MATCH_CTL = 8'h14;
  localparam logic [7:0]  OFS_CNT_CTL   = 8'h18;
  localparam logic [7:0]  OFS_PWM_CTL   = 8'h1c;
  localparam logic [7:0]  OFS_RELEASE   = 8'h20;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h24;
  localparam logic [7:0]  OFS_CAP_CTL   = 8'h28;
  localparam logic [7:0]  OFS_MATCH0    = 8'h40;
  localparam logic [7:0]  OFS_CAPT0     = 8'h60;
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_RST_BIT  = 1;
  localparam int unsigned CTRL_PWM_BIT  = 3;
  localparam int unsigned CAP_IRQ_BASE  = 7;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;
  localparam logic [31:0] RESET_VALUE   = 32'h0000_0000;
  typedef struct packed {
    logic        edge_en;
    logic        edge_rise;
    logic        edge_fall;
    logic        sel;
  } mbpwm_cnt_cfg_t;
endpackage : mbpwm_pkg

//--- hw/mbpwm_top.sv
`timescale 1ns/1ns
module mbpwm_top
  import mbpwm_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 resetn,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic [NUM_CAP-1:0]   cap_in,
  output logic [NUM_OUT-1:0]        pwm_out,
  output logic                      irq
);

  logic [31:0]            count_reg;
  logic [31:0]            pre_cnt_reg;
  logic [31:0]            pre_max_reg;
  logic [3:0]             ctrl_reg;
  logic [20:0]            match_ctl_reg;
  logic [3:0]             cnt_ctl_reg;
  logic [5:0]             cap_ctl_reg;
  logic [13:0]            pwm_ctl_reg;
  logic [NUM_MATCH-1:0]   release_reg;
  logic [NUM_IRQ-1:0]     irq_stat_reg;
  logic [NUM_IRQ-1:0]     irq_mask_reg;
  logic [31:0]            match_shadow [NUM_MATCH];
  logic [31:0]            match_active [NUM_MATCH];
  logic [31:0]            capt_reg [NUM_CAP];
  logic [NUM_CAP-1:0]     cap_s1_reg;
  logic [NUM_CAP-1:0]     cap_s2_reg;
  logic [NUM_CAP-1:0]     cap_s3_reg;
  logic [NUM_CAP-1:0]     cap_rise;
  logic [NUM_CAP-1:0]     cap_fall;
  logic [NUM_CAP-1:0]     cap_event;
  logic [NUM_MATCH-1:0]   match_hit;
  logic                   tick;
  logic                   pre_wrap;
  logic                   cnt_edge;
  logic                   any_reset;
  logic                   any_stop;
  logic                   run;
  logic                   pwm_mode;
  logic                   aw_reg;
  logic                   w_reg;
  logic [7:0]             awaddr_reg;
  logic [31:0]            wdata_reg;
  logic                   wr_fire;
  logic                   wr_ok;
  logic                   rd_ok;
  logic [31:0]            rd_val;
  mbpwm_cnt_cfg_t         cnt_cfg;

  assign run      = ctrl_reg[CTRL_EN_BIT] && !ctrl_reg[CTRL_RST_BIT];
  assign pwm_mode = ctrl_reg[CTRL_PWM_BIT];
  assign cnt_cfg  = mbpwm_cnt_cfg_t'({cnt_ctl_reg[1:0] != 2'b00, cnt_ctl_reg[0], cnt_ctl_reg[1], cnt_ctl_reg[2]});

  // Capture input synchroniser and edge detect
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cap_s1_reg <= '0;
      cap_s2_reg <= '0;
      cap_s3_reg <= '0;
    end
    else
    begin
      cap_s1_reg <= cap_in;
      cap_s2_reg <= cap_s1_reg;
      cap_s3_reg <= cap_s2_reg;
    end
  end
  assign cap_rise = cap_s2_reg & ~cap_s3_reg;
  assign cap_fall = ~cap_s2_reg & cap_s3_reg;

  // Counter-mode edge source
  assign cnt_edge = (cnt_cfg.edge_rise && cap_rise[cnt_cfg.sel]) ||
                    (cnt_cfg.edge_fall && cap_fall[cnt_cfg.sel]);
  assign tick     = run && (cnt_cfg.edge_en ? cnt_edge : 1'b1);
  assign pre_wrap = tick && (pre_cnt_reg == pre_max_reg);

  // Match compare against active values
  genvar gi;
  generate
    for (gi = 0; gi < NUM_MATCH; gi++)
    begin : g_match
      assign match_hit[gi] = pre_wrap && (count_reg == match_active[gi]);
    end
  endgenerate

  always_comb
  begin
    any_reset = 1'b0;
    any_stop  = 1'b0;
    for (int i = 0; i < NUM_MATCH; i++)
    begin
      any_reset = any_reset || (match_hit[i] && match_ctl_reg[3*i+1]);
      any_stop  = any_stop  || (match_hit[i] && match_ctl_reg[3*i+2]);
    end
    if (pwm_mode && match_hit[0])
    begin
      any_reset = 1'b1;
    end
  end

  // Prescaler and counter
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pre_cnt_reg <= RESET_VALUE;
      count_reg   <= RESET_VALUE;
    end
    else if (ctrl_reg[CTRL_RST_BIT])
    begin
      pre_cnt_reg <= RESET_VALUE;
      count_reg   <= RESET_VALUE;
    end
    else if (tick)
    begin
      if (pre_wrap)
      begin
        pre_cnt_reg <= RESET_VALUE;
        count_reg   <= any_reset ? RESET_VALUE : count_reg + 32'h0000_0001;
      end
      else
      begin
        pre_cnt_reg <= pre_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // Active match load: immediate in timer mode, on cycle restart or counter reset in PWM mode once released
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < NUM_MATCH; i++)
      begin
        match_active[i] <= RESET_VALUE;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_MATCH; i++)
      begin
        if (!pwm_mode || (release_reg[i] && (any_reset || ctrl_reg[CTRL_RST_BIT])))
        begin
          match_active[i] <= match_shadow[i];
        end
      end
    end
  end

  // PWM outputs; channel n uses match n, double-edge uses n-1 and n
  generate
    for (gi = 1; gi <= NUM_OUT; gi++)
    begin : g_pwm
      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          pwm_out[gi-1] <= 1'b0;
        end
        else if (!pwm_mode || !pwm_ctl_reg[gi+7])
        begin
          pwm_out[gi-1] <= 1'b0;
        end
        else if (gi > 1 && pwm_ctl_reg[gi])
        begin
          if (match_hit[gi])
          begin
            pwm_out[gi-1] <= 1'b0;
          end
          else if (match_hit[gi-1])
          begin
            pwm_out[gi-1] <= 1'b1;
          end
        end
        else if (match_hit[gi])
        begin
          pwm_out[gi-1] <= 1'b0;
        end
        else if (match_hit[0])
        begin
          pwm_out[gi-1] <= 1'b1;
        end
      end
    end
  endgenerate

  // Capture channels
  generate
    for (gi = 0; gi < NUM_CAP; gi++)
    begin : g_cap
      assign cap_event[gi] = (cap_ctl_reg[3*gi] && cap_rise[gi]) || (cap_ctl_reg[3*gi+1] && cap_fall[gi]);
      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          capt_reg[gi] <= RESET_VALUE;
        end
        else if (cap_event[gi])
        begin
          capt_reg[gi] <= count_reg;
        end
      end
    end
  endgenerate

  // AXI4-Lite write channel
  assign s_axi_awready = !aw_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_reg && !s_axi_bvalid;
  assign wr_fire       = aw_reg && w_reg && !s_axi_bvalid;
  assign wr_ok         = (awaddr_reg[1:0] == 2'b00) &&
                         ((awaddr_reg <= OFS_CAP_CTL) ||
                          (awaddr_reg >= OFS_MATCH0 && awaddr_reg < OFS_MATCH0 + 8'(4*NUM_MATCH)));

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_reg       <= 1'b0;
      w_reg        <= 1'b0;
      awaddr_reg   <= '0;
      wdata_reg    <= RESET_VALUE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_reg     <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_reg     <= 1'b1;
        wdata_reg <= s_axi_wdata;
      end
      if (wr_fire)
      begin
        aw_reg       <= 1'b0;
        w_reg        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control registers
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_reg      <= '0;
      pre_max_reg   <= RESET_VALUE;
      match_ctl_reg <= '0;
      cnt_ctl_reg   <= '0;
      cap_ctl_reg   <= '0;
      pwm_ctl_reg   <= '0;
      irq_mask_reg  <= '0;
      for (int i = 0; i < NUM_MATCH; i++)
      begin
        match_shadow[i] <= RESET_VALUE;
      end
    end
    else
    begin
      if (wr_fire && wr_ok)
      begin
        case (awaddr_reg)
          OFS_CTRL:      ctrl_reg      <= wdata_reg[3:0];
          OFS_PRE_MAX:   pre_max_reg   <= wdata_reg;
          OFS_MATCH_CTL: match_ctl_reg <= wdata_reg[20:0];
          OFS_CNT_CTL:   cnt_ctl_reg   <= wdata_reg[3:0];
          OFS_CAP_CTL:   cap_ctl_reg   <= wdata_reg[5:0];
          OFS_PWM_CTL:   pwm_ctl_reg   <= wdata_reg[13:0];
          OFS_IRQ_MASK:  irq_mask_reg  <= wdata_reg[NUM_IRQ-1:0];
          default:
          begin
            if (awaddr_reg >= OFS_MATCH0)
            begin
              match_shadow[3'((awaddr_reg - OFS_MATCH0) >> 2)] <= wdata_reg;
            end
          end
        endcase
      end
      // Stop wins over a coincident enable write
      if (any_stop)
      begin
        ctrl_reg[CTRL_EN_BIT] <= 1'b0;
      end
    end
  end

  // Release latch: set by software, cleared when taken at cycle start
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      release_reg <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_MATCH; i++)
      begin
        if (wr_fire && wr_ok && awaddr_reg == OFS_RELEASE && wdata_reg[i])
        begin
          release_reg[i] <= 1'b1;
        end
        else if (any_reset || ctrl_reg[CTRL_RST_BIT])
        begin
          release_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Sticky interrupt status, set wins over write-one-clear
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_stat_reg <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_MATCH; i++)
      begin
        if (match_hit[i] && match_ctl_reg[3*i])
        begin
          irq_stat_reg[i] <= 1'b1;
        end
        else if (wr_fire && wr_ok && awaddr_reg == OFS_IRQ_STAT && wdata_reg[i])
        begin
          irq_stat_reg[i] <= 1'b0;
        end
      end
      for (int j = 0; j < NUM_CAP; j++)
      begin
        if (cap_event[j] && cap_ctl_reg[3*j+2])
        begin
          irq_stat_reg[CAP_IRQ_BASE+j] <= 1'b1;
        end
        else if (wr_fire && wr_ok && awaddr_reg == OFS_IRQ_STAT && wdata_reg[CAP_IRQ_BASE+j])
        begin
          irq_stat_reg[CAP_IRQ_BASE+j] <= 1'b0;
        end
      end
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_ok         = (s_axi_araddr[1:0] == 2'b00) &&
                         ((s_axi_araddr <= OFS_CAP_CTL) ||
                          (s_axi_araddr >= OFS_MATCH0 && s_axi_araddr < OFS_MATCH0 + 8'(4*NUM_MATCH)) ||
                          (s_axi_araddr >= OFS_CAPT0 && s_axi_araddr < OFS_CAPT0 + 8'(4*NUM_CAP)));
  always_comb
  begin
    rd_val = '0;
    case (s_axi_araddr)
      OFS_IRQ_STAT:  rd_val = 32'(irq_stat_reg);
      OFS_CTRL:      rd_val = 32'(ctrl_reg);
      OFS_COUNT:     rd_val = count_reg;
      OFS_PRE_MAX:   rd_val = pre_max_reg;
      OFS_PRE_CNT:   rd_val = pre_cnt_reg;
      OFS_MATCH_CTL: rd_val = 32'(match_ctl_reg);
      OFS_CNT_CTL:   rd_val = 32'(cnt_ctl_reg);
      OFS_PWM_CTL:   rd_val = 32'(pwm_ctl_reg);
      OFS_RELEASE:   rd_val = 32'(release_reg);
      OFS_IRQ_MASK:  rd_val = 32'(irq_mask_reg);
      OFS_CAP_CTL:   rd_val = 32'(cap_ctl_reg);
      default:
      begin
        if (s_axi_araddr >= OFS_CAPT0)
        begin
          rd_val = capt_reg[1'((s_axi_araddr - OFS_CAPT0) >> 2)];
        end
        else if (s_axi_araddr >= OFS_MATCH0)
        begin
          rd_val = match_shadow[3'((s_axi_araddr - OFS_MATCH0) >> 2)];
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= RESET_VALUE;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_ok ? rd_val : RESET_VALUE;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  sequence halt_hold_s;
    !ctrl_reg[CTRL_EN_BIT] ##1 $stable(count_reg);
  endsequence

  period_restart_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (pwm_mode && match_hit[0] && !ctrl_reg[CTRL_RST_BIT]) |=> count_reg == 32'h0) else $error("no restart");
  single_fall_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (pwm_mode && pwm_ctl_reg[8] && match_hit[1]) |=> !pwm_out[0]) else $error("no fall");
  single_rise_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (pwm_mode && pwm_ctl_reg[8] && !match_hit[1] && match_hit[0]) |=> pwm_out[0]) else $error("no rise");
  double_rise_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (pwm_mode && pwm_ctl_reg[9] && pwm_ctl_reg[2] && match_hit[1] && !match_hit[2]) |=> pwm_out[1])
    else $error("no double-edge rise");
  stop_halt_a: assert property (@(posedge core_clk) disable iff (!resetn)
    any_stop |=> halt_hold_s) else $error("no stop");
  match_reset_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (any_reset && !ctrl_reg[CTRL_RST_BIT]) |=> count_reg == 32'h0) else $error("no clear");
  pre_wrap_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (pre_wrap && !ctrl_reg[CTRL_RST_BIT]) |=> pre_cnt_reg == 32'h0) else $error("prescale");
  capture_copy_a: assert property (@(posedge core_clk) disable iff (!resetn)
    cap_event[0] |=> capt_reg[0] == $past(count_reg)) else $error("capture");
  release_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (pwm_mode && $past(pwm_mode) && !$past(release_reg[1])) |-> $stable(match_active[1])) else $error("early load");
  irq_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (match_hit[0] && match_ctl_reg[0]) |=> irq_stat_reg[0]) else $error("irq");

endmodule : mbpwm_top

//--- verif/mbpwm_load.sv
`timescale 1ns/1ns
module mbpwm_load
  import mbpwm_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic [NUM_OUT-1:0] pwm_out,
  output int unsigned             hi_len [NUM_OUT],
  output int unsigned             per_len [NUM_OUT]
);
  int unsigned        hi_cnt_reg [NUM_OUT];
  int unsigned        per_cnt_reg [NUM_OUT];
  logic [NUM_OUT-1:0] prev_reg = '0;

  // Measures high time and rise-to-rise period of each load
  always @(posedge core_clk)
  begin
    for (int i = 0; i < NUM_OUT; i++)
    begin
      per_cnt_reg[i] <= (pwm_out[i] && !prev_reg[i]) ? 1 : per_cnt_reg[i] + 1;
      if (pwm_out[i] && !prev_reg[i])
        per_len[i] <= per_cnt_reg[i];
      if (!pwm_out[i] && prev_reg[i])
        hi_len[i] <= hi_cnt_reg[i];
      hi_cnt_reg[i] <= pwm_out[i] ? hi_cnt_reg[i] + 1 : 0;
    end
    prev_reg <= pwm_out;
  end
endmodule : mbpwm_load

//--- verif/tb_mbpwm_top.sv
`timescale 1ns/1ns
module tb_mbpwm_top;
  import mbpwm_pkg::*;
  logic               core_clk = 1'b0;
  logic               resetn = 1'b0;
  logic [7:0]         s_axi_awaddr = '0;
  logic               s_axi_awvalid = 1'b0;
  logic               s_axi_awready;
  logic [31:0]        s_axi_wdata = '0;
  logic               s_axi_wvalid = 1'b0;
  logic               s_axi_wready;
  logic [1:0]         s_axi_bresp;
  logic               s_axi_bvalid;
  logic               s_axi_bready = 1'b0;
  logic [7:0]         s_axi_araddr = '0;
  logic               s_axi_arvalid = 1'b0;
  logic               s_axi_arready;
  logic [31:0]        s_axi_rdata;
  logic [1:0]         s_axi_rresp;
  logic               s_axi_rvalid;
  logic               s_axi_rready = 1'b0;
  logic [NUM_CAP-1:0] cap_in = '0;
  logic [NUM_OUT-1:0] pwm_out;
  logic               irq;
  int unsigned        hi_len [NUM_OUT];
  int unsigned        per_len [NUM_OUT];
  logic [33:0]        exp_q [$];
  int                 err_total = 0;
  int                 compares = 0;
  int                 cyc_cnt = 0;
  int                 m;

  always #2 core_clk = ~core_clk;

  mbpwm_top u_mbpwm_top (
    .core_clk(core_clk), .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cap_in(cap_in), .pwm_out(pwm_out), .irq(irq)
  );

  mbpwm_load u_mbpwm_load (.core_clk(core_clk), .pwm_out(pwm_out), .hi_len(hi_len), .per_len(per_len));

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // Hang guard
  always @(posedge core_clk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000)
    begin
      err_total++;
      end_of_test();
    end
  end

  // Read data monitor against the oldest note
  always @(posedge core_clk)
    if (s_axi_rvalid === 1'b1 && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    chk({32'h0, s_axi_bresp}, {32'h0, RESP_OKAY});
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
    exp_q.push_back({r, d});
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic pulse(input int i, input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      cap_in[i] <= 1'b1;
      repeat (4) @(posedge core_clk);
      cap_in[i] <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask : pulse

  task automatic do_reset;
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
  endtask : do_reset

  initial
  begin
    void'($urandom(32'h3e4b903f));
    m = $urandom_range(6, 1);
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    // Reset values and unmapped place
    rd(OFS_CTRL, RESP_OKAY, RESET_VALUE);
    rd(OFS_COUNT, RESP_OKAY, RESET_VALUE);
    rd(OFS_PRE_CNT, RESP_OKAY, RESET_VALUE);
    rd(OFS_IRQ_STAT, RESP_OKAY, RESET_VALUE);
    rd(8'h3c, RESP_SLVERR, 32'h0);
    $display("test reset_values done");
    // Single and double edge mix, prescale by 2, period 12 counts
    wr(OFS_PRE_MAX, 32'h1);
    wr(OFS_MATCH0, 32'hb);
    wr(OFS_MATCH0 + 8'h04, 32'(m));
    wr(OFS_MATCH0 + 8'h08, 32'h8);
    wr(OFS_RELEASE, 32'h7);
    wr(OFS_PWM_CTL, 32'h304);
    wr(OFS_CTRL, 32'hb);
    wr(OFS_CTRL, 32'h9);
    repeat (100) @(posedge core_clk);
    chk(per_len[0], 24);
    chk(per_len[1], 24);
    chk(hi_len[0], (m + 1) * 2);
    chk(hi_len[1], (8 - m) * 2);
    chk({33'h0, pwm_out[2]}, 34'h0);
    // Unreleased shadow must not take effect
    wr(OFS_MATCH0 + 8'h04, 32'ha);
    repeat (100) @(posedge core_clk);
    chk(hi_len[0], (m + 1) * 2);
    wr(OFS_RELEASE, 32'h2);
    repeat (100) @(posedge core_clk);
    chk(hi_len[0], 22);
    chk(hi_len[1], 20);
    chk(per_len[1], 24);
    $display("test pwm_edges done");
    // Stop on match with interrupt
    do_reset();
    wr(OFS_MATCH0 + 8'h04, 32'h5);
    wr(OFS_MATCH_CTL, 32'h29);
    wr(OFS_CTRL, 32'h3);
    wr(OFS_CTRL, 32'h1);
    repeat (30) @(posedge core_clk);
    rd(OFS_CTRL, RESP_OKAY, 32'h0);
    rd(OFS_IRQ_STAT, RESP_OKAY, 32'h3);
    chk({33'h0, irq}, 34'h0);
    wr(OFS_IRQ_MASK, 32'h2);
    @(posedge core_clk);
    chk({33'h0, irq}, 34'h1);
    wr(OFS_IRQ_STAT, 32'h2);
    @(posedge core_clk);
    chk({33'h0, irq}, 34'h0);
    $display("test stop_irq done");
    // Counter mode, capture and reset on match
    do_reset();
    wr(OFS_CNT_CTL, 32'h1);
    wr(OFS_CAP_CTL, 32'h2a);
    wr(OFS_MATCH0 + 8'h08, 32'h7);
    wr(OFS_MATCH_CTL, 32'h80);
    wr(OFS_IRQ_MASK, 32'h100);
    wr(OFS_CTRL, 32'h3);
    wr(OFS_CTRL, 32'h1);
    pulse(0, 5);
    rd(OFS_COUNT, RESP_OKAY, 32'h5);
    pulse(1, 1);
    rd(OFS_CAPT0 + 8'h04, RESP_OKAY, 32'h5);
    rd(OFS_IRQ_STAT, RESP_OKAY, 32'h100);
    chk({33'h0, irq}, 34'h1);
    pulse(0, 4);
    rd(OFS_COUNT, RESP_OKAY, 32'h1);
    rd(OFS_CAPT0, RESP_OKAY, 32'h1);
    $display("test counter_capture done");
    end_of_test();
  end
endmodule : tb_mbpwm_top
